// ===== rtl/detection_threshold_registers.sv
// detection_threshold_registers: runtime threshold bank of a one-channel
// capacitive proximity controller, with derived effective thresholds.
// assumes: the serial host engine presents a same-clock register port;
// programmed settings are stable inputs; the strap is an asynchronous pin.
//
// Summary of operation
// - movement field holds only 0 to 30
// - effective movement threshold is field times two
// - movement field zero means movement always triggers
// - programmed movement copied into field at start-up
// - touch threshold is value times four plus four
// - programmed touch copied into register at start-up
// - strap low or register mode: proximity 4 to 10
// - strap high outside register mode: proximity spans 8 to 14
// - programmed proximity copied into register at start-up
// - tracking threshold is 8 bits, default 3
`timescale 1ns/10ps
`default_nettype none

module detection_threshold_registers (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [7:0]  reg_address,
    input  wire logic        reg_write,
    input  wire logic [7:0]  reg_write_data,
    input  wire logic        reg_read,
    output logic      [7:0]  reg_read_data,
    input  wire logic [4:0]  programmed_movement,
    input  wire logic [7:0]  programmed_touch,
    input  wire logic [3:0]  programmed_near,
    input  wire logic        threshold_select_strap,
    input  wire logic        i2c_mode,
    output logic             loaded,
    output logic      [5:0]  movement_threshold,
    output logic             movement_always,
    output logic      [10:0] touch_threshold,
    output logic      [3:0]  near_threshold,
    output logic      [7:0]  drift_tracking_threshold
);

    typedef struct packed {
        threshold_bank_pkg::phase_type phase;
        logic        strap_meta;
        logic        strap_sync;
        logic [4:0]  movement;
        logic [7:0]  touch_level;
        logic [3:0]  near_level;
        logic [7:0]  drift_tracking_level;
        logic [7:0]  read_data;
        logic [5:0]  movement_eff;
        logic        movement_always;
        logic [10:0] touch_eff;
        logic [3:0]  near_eff;
    } bank_state_type;

    bank_state_type state;
    bank_state_type next_state;

    logic [4:0] movement_source;
    logic [4:0] movement_limited;
    logic [3:0] near_low;
    logic [3:0] near_high;
    logic [3:0] near_limited;
    logic [3:0] near_candidate;
    logic       write_ok;

    ////////////////////////////////////////////////////////////////////////
    // limiters

    range_clamp #(
        .WIDTH (threshold_bank_pkg::MOVEMENT_WIDTH)
    ) movement_limit (
        .value   (movement_source),
        .low     (threshold_bank_pkg::MOVEMENT_MIN),
        .high    (threshold_bank_pkg::MOVEMENT_MAX),
        .clamped (movement_limited)
    );

    // the register keeps what was written; only the effective value clamps
    // fed with the value being stored so the output follows on the same edge
    range_clamp #(
        .WIDTH (threshold_bank_pkg::NEAR_WIDTH)
    ) near_limit (
        .value   (near_candidate),
        .low     (near_low),
        .high    (near_high),
        .clamped (near_limited)
    );

    always_comb begin
        if (state.strap_sync && !i2c_mode) begin
            near_low  = threshold_bank_pkg::NEAR_HIGH_MIN;
            near_high = threshold_bank_pkg::NEAR_HIGH_MAX;
        end else begin
            near_low  = threshold_bank_pkg::NEAR_LOW_MIN;
            near_high = threshold_bank_pkg::NEAR_LOW_MAX;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    // writes are ignored until the start-up copy is done so they cannot be overwritten by it
    assign write_ok = reg_write && (state.phase == threshold_bank_pkg::RUN);

    always_comb begin
        if (state.phase == threshold_bank_pkg::LOAD) begin
            movement_source = programmed_movement;
            near_candidate  = programmed_near;
        end else begin
            // upper bits set must still land on the top of the range
            if (reg_write_data[7:5] != 3'h0) begin
                movement_source = 5'h1F;
            end else begin
                movement_source = reg_write_data[4:0];
            end
            if (write_ok && reg_address == threshold_bank_pkg::NEAR_OFFSET) begin
                near_candidate = reg_write_data[3:0];
            end else begin
                near_candidate = state.near_level;
            end
        end
    end

    always_comb begin
        next_state = state;
        next_state.strap_meta = threshold_select_strap;
        next_state.strap_sync = state.strap_meta;
        case (state.phase)
            threshold_bank_pkg::LOAD: begin
                next_state.movement    = movement_limited;
                next_state.touch_level = programmed_touch;
                next_state.near_level  = programmed_near;
                next_state.phase       = threshold_bank_pkg::RUN;
            end
            threshold_bank_pkg::RUN: begin
                next_state.phase = threshold_bank_pkg::RUN;
            end
            default: begin
                next_state.phase = threshold_bank_pkg::LOAD;
            end
        endcase
        if (write_ok) begin
            if (reg_address == threshold_bank_pkg::MOVEMENT_OFFSET) begin
                next_state.movement = movement_limited;
            end else if (reg_address == threshold_bank_pkg::TOUCH_OFFSET) begin
                next_state.touch_level = reg_write_data;
            end else if (reg_address == threshold_bank_pkg::NEAR_OFFSET) begin
                next_state.near_level = reg_write_data[3:0];
            end else if (reg_address == threshold_bank_pkg::DRIFT_OFFSET) begin
                next_state.drift_tracking_level = reg_write_data;
            end
        end
        if (reg_read) begin
            if (reg_address == threshold_bank_pkg::MOVEMENT_OFFSET) begin
                next_state.read_data = {3'h0, state.movement};
            end else if (reg_address == threshold_bank_pkg::TOUCH_OFFSET) begin
                next_state.read_data = state.touch_level;
            end else if (reg_address == threshold_bank_pkg::NEAR_OFFSET) begin
                next_state.read_data = {4'h0, state.near_level};
            end else if (reg_address == threshold_bank_pkg::DRIFT_OFFSET) begin
                next_state.read_data = state.drift_tracking_level;
            end else begin
                next_state.read_data = threshold_bank_pkg::UNMAPPED_READ;
            end
        end
        // effective values follow the stored fields in the same edge
        next_state.movement_eff    = {next_state.movement, 1'b0};
        next_state.movement_always = (next_state.movement == 5'h00);
        next_state.touch_eff = {1'b0, next_state.touch_level, 2'b00}
                             + threshold_bank_pkg::TOUCH_OFFSET_ADD;
        next_state.near_eff  = near_limited;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state.phase                <= threshold_bank_pkg::LOAD;
            state.strap_meta           <= 1'b0;
            state.strap_sync           <= 1'b0;
            state.movement             <= threshold_bank_pkg::MOVEMENT_RESET;
            state.touch_level          <= threshold_bank_pkg::TOUCH_RESET;
            state.near_level           <= threshold_bank_pkg::NEAR_RESET;
            state.drift_tracking_level <= threshold_bank_pkg::DRIFT_RESET;
            state.read_data            <= threshold_bank_pkg::READ_RESET;
            state.movement_eff         <= 6'h00;
            state.movement_always      <= 1'b1;
            state.touch_eff            <= threshold_bank_pkg::TOUCH_OFFSET_ADD;
            state.near_eff             <= threshold_bank_pkg::NEAR_LOW_MIN;
        end else begin
            state <= next_state;
        end
    end

    assign loaded                   = (state.phase == threshold_bank_pkg::RUN);
    assign reg_read_data            = state.read_data;
    assign movement_threshold       = state.movement_eff;
    assign movement_always          = state.movement_always;
    assign touch_threshold          = state.touch_eff;
    assign near_threshold           = state.near_eff;
    assign drift_tracking_threshold = state.drift_tracking_level;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking main_clock @(posedge clock);
    endclocking
    default disable iff (reset);

    AST_MOVE_RANGE: assert property (state.movement <= 5'h1E)
        else $error("movement field above 30");
    AST_MOVE_DOUBLE: assert property (loaded && reg_write && reg_address == 8'h09 && reg_write_data <= 8'h1E
        |=> movement_threshold == {$past(reg_write_data[4:0]), 1'b0})
        else $error("movement threshold not twice the written value");
    AST_MOVE_CLAMP: assert property (loaded && reg_write && reg_address == 8'h09 && reg_write_data > 8'h1E
        |=> movement_threshold == 6'h3C)
        else $error("movement write above 30 not held at 30");
    AST_MOVE_ALWAYS: assert property (loaded |-> (movement_always == (movement_threshold == 6'h00)))
        else $error("movement always flag does not match zero field");
    AST_LOAD_MOVE: assert property ($rose(loaded) |-> state.movement ==
        ($past(programmed_movement) > 5'h1E ? 5'h1E : $past(programmed_movement)))
        else $error("programmed movement not copied at start-up");
    AST_TOUCH_SCALE: assert property (loaded && reg_write && reg_address == 8'h0A
        |=> touch_threshold == {1'b0, $past(reg_write_data), 2'b00} + 11'h004)
        else $error("touch threshold not value times four plus four");
    AST_LOAD_TOUCH: assert property ($rose(loaded) |-> touch_threshold ==
        {1'b0, $past(programmed_touch), 2'b00} + 11'h004)
        else $error("programmed touch not copied at start-up");
    AST_NEAR_LOW: assert property ($past(loaded) && (!$past(state.strap_sync) || $past(i2c_mode))
        |-> near_threshold >= 4'h4 && near_threshold <= 4'hA)
        else $error("proximity threshold outside 4 to 10");
    AST_NEAR_HIGH: assert property ($past(loaded) && $past(state.strap_sync) && !$past(i2c_mode)
        |-> near_threshold >= 4'h8 && near_threshold <= 4'hE)
        else $error("proximity threshold outside 8 to 14");
    AST_LOAD_NEAR: assert property ($rose(loaded) |-> state.near_level == $past(programmed_near))
        else $error("programmed proximity not copied at start-up");
    AST_DRIFT_DEFAULT: assert property ($rose(loaded) |-> drift_tracking_threshold == 8'h03)
        else $error("tracking threshold default not 3");
    AST_NEAR_RESERVED: assert property (reg_read && reg_address == 8'h0B |=> reg_read_data[7:4] == 4'h0)
        else $error("proximity reserved bits read non-zero");

    COVER_MOVE_ZERO: cover property (loaded && reg_write && reg_address == 8'h09 && reg_write_data == 8'h00);
    COVER_STRAP_HIGH: cover property (loaded && state.strap_sync && !i2c_mode);
    COVER_MOVE_OVER: cover property (loaded && reg_write && reg_address == 8'h09 && reg_write_data > 8'h1E);

endmodule

`default_nettype wire

// ===== rtl/threshold_bank_pkg.sv
// package: register offsets, reset values and field limits of the
// detection threshold register bank.
// assumes: one 8-bit register port, 50 MHz clock, asynchronous reset.
package threshold_bank_pkg;

    localparam int unsigned CLOCK_HZ = 50_000_000;

    // register offsets in the controller memory map
    localparam logic [7:0] MOVEMENT_OFFSET = 8'h09;
    localparam logic [7:0] TOUCH_OFFSET    = 8'h0A;
    localparam logic [7:0] NEAR_OFFSET     = 8'h0B;
    localparam logic [7:0] DRIFT_OFFSET    = 8'h0C;

    // field widths
    localparam int unsigned MOVEMENT_WIDTH = 5;
    localparam int unsigned NEAR_WIDTH     = 4;

    // values held between reset and the start-up copy
    localparam logic [4:0] MOVEMENT_RESET = 5'h00;
    localparam logic [7:0] TOUCH_RESET    = 8'h00;
    localparam logic [3:0] NEAR_RESET     = 4'h0;
    localparam logic [7:0] DRIFT_RESET    = 8'h03;
    localparam logic [7:0] READ_RESET     = 8'h00;
    localparam logic [7:0] UNMAPPED_READ  = 8'h00;

    // movement field limits
    localparam logic [4:0] MOVEMENT_MIN   = 5'h00;
    localparam logic [4:0] MOVEMENT_MAX   = 5'h1E;

    // touch threshold = value * 4 + 4
    localparam logic [10:0] TOUCH_OFFSET_ADD = 11'h004;

    // proximity ranges: low strap or register mode, and high strap
    localparam logic [3:0] NEAR_LOW_MIN  = 4'h4;
    localparam logic [3:0] NEAR_LOW_MAX  = 4'hA;
    localparam logic [3:0] NEAR_HIGH_MIN = 4'h8;
    localparam logic [3:0] NEAR_HIGH_MAX = 4'hE;

    typedef enum logic [1:0] {
        LOAD = 2'b01,
        RUN  = 2'b10
    } phase_type;

endpackage

// ===== rtl/range_clamp.sv
// range_clamp: limits an unsigned value to an inclusive window.
// assumes: low <= high is held by the caller.
`timescale 1ns/10ps
`default_nettype none

module range_clamp #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic [WIDTH-1:0] value,
    input  wire logic [WIDTH-1:0] low,
    input  wire logic [WIDTH-1:0] high,
    output logic      [WIDTH-1:0] clamped
);

    if (WIDTH < 1) begin : g_width_check
        $error("range_clamp: WIDTH must be at least 1");
    end

    always_comb begin
        if (value < low) begin
            clamped = low;
        end else if (value > high) begin
            clamped = high;
        end else begin
            clamped = value;
        end
    end

endmodule

`default_nettype wire

// ===== tb/threshold_host.sv
// threshold_host: behavioural host that adjusts thresholds over the register port.
// assumes: device samples strobes on the rising edge; host changes pins on the falling edge.
`timescale 1ns/10ps
`default_nettype none

module threshold_host (
    input  wire logic       clock,
    output logic      [7:0] reg_address,
    output logic            reg_write,
    output logic      [7:0] reg_write_data,
    output logic            reg_read,
    input  wire logic [7:0] reg_read_data
);

    initial begin
        reg_address    = 8'h00;
        reg_write      = 1'b0;
        reg_write_data = 8'h00;
        reg_read       = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one strobe cycle per access; data is inverted once released so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_address    = a;
        reg_write_data = d;
        reg_write      = 1'b1;
        @(negedge clock);
        reg_write      = 1'b0;
        reg_write_data = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_address = a;
        reg_read    = 1'b1;
        @(negedge clock);
        reg_read    = 1'b0;
        d           = reg_read_data;
    endtask

    // low tracking level normally, a higher one for a noisy board
    task automatic set_tracking(input logic noisy);
        wr(8'h0C, noisy ? 8'h40 : 8'h02);
    endtask

endmodule

`default_nettype wire

// ===== tb/tb.sv
// tb: self-checking bench for the detection threshold register bank.
// assumes: threshold_host drives the register port; 50 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic        clock                  = 1'b0;
    logic        reset                  = 1'b1;
    logic [4:0]  programmed_movement    = 5'h07;
    logic [7:0]  programmed_touch       = 8'h10;
    logic [3:0]  programmed_near        = 4'h6;
    logic        threshold_select_strap = 1'b0;
    logic        i2c_mode               = 1'b0;
    logic [7:0]  reg_address, reg_write_data, reg_read_data, drift_tracking_threshold, rd, f;
    logic        reg_write, reg_read, loaded, movement_always;
    logic [5:0]  movement_threshold;
    logic [10:0] touch_threshold;
    logic [3:0]  near_threshold;
    logic [7:0]  mv [5] = '{8'h00, 8'h01, 8'h1E, 8'h1F, 8'h25};
    int          mismatches = 0;
    int          num_checks = 0;

    always #10 clock = ~clock;

    detection_threshold_registers DUT (.clock, .reset, .reg_address, .reg_write, .reg_write_data,
        .reg_read, .reg_read_data, .programmed_movement, .programmed_touch, .programmed_near,
        .threshold_select_strap, .i2c_mode, .loaded, .movement_threshold, .movement_always,
        .touch_threshold, .near_threshold, .drift_tracking_threshold);

    threshold_host HOST (.clock, .reg_address, .reg_write, .reg_write_data, .reg_read, .reg_read_data);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge clock);
        chk(movement_always, 1'b1, "movement zero in reset");
        chk(drift_tracking_threshold, 8'h03, "tracking default");
        reset = 1'b0;
        for (int i = 0; i < 8 && loaded !== 1'b1; i++) @(negedge clock);
        chk(loaded, 1'b1, "start-up copy done");
        chk(movement_threshold, 6'h0E, "movement copied");
        chk(touch_threshold, 11'h044, "touch copied");
        chk(near_threshold, 4'h6, "proximity copied");
        // programmed settings must no longer matter
        programmed_touch    = 8'h55;
        programmed_movement = 5'h03;
        programmed_near     = 4'h9;
        HOST.rd(8'h0A, rd);
        chk(rd, 8'h10, "touch readback");
        chk(movement_threshold, 6'h0E, "movement kept");
        HOST.rd(8'h0B, rd);
        chk(rd, 8'h06, "proximity readback");
        HOST.rd(8'h0C, rd);
        chk(rd, 8'h03, "tracking readback");
        HOST.rd(8'h20, rd);
        chk(rd, 8'h00, "unmapped read");
        for (int i = 0; i < 5; i++) begin
            HOST.wr(8'h09, mv[i]);
            f = (mv[i] > 8'h1E) ? 8'h1E : mv[i];
            chk(movement_threshold, {f[4:0], 1'b0}, "movement doubled");
            chk(movement_always, f == 8'h00, "movement always");
            HOST.rd(8'h09, rd);
            chk(rd, f, "movement field range");
        end
        for (int i = 0; i < 2; i++) begin
            f = i ? 8'hFF : 8'h00;
            HOST.wr(8'h0A, f);
            chk(touch_threshold, ({3'h0, f} << 2) + 11'h004, "touch scaling");
            HOST.rd(8'h0A, rd);
            chk(rd, f, "touch readback");
        end
        HOST.wr(8'h0B, 8'hFC);
        HOST.rd(8'h0B, rd);
        chk(rd, 8'h0C, "reserved bits zero");
        chk(near_threshold, 4'hA, "low range top");
        threshold_select_strap = 1'b1;
        repeat (4) @(negedge clock);
        chk(near_threshold, 4'hC, "high range value");
        HOST.wr(8'h0B, 8'h02);
        chk(near_threshold, 4'h8, "high range bottom");
        HOST.wr(8'h0B, 8'h0F);
        chk(near_threshold, 4'hE, "high range top");
        i2c_mode = 1'b1;
        repeat (2) @(negedge clock);
        chk(near_threshold, 4'hA, "register mode forces low range");
        HOST.wr(8'h0C, 8'hFF);
        chk(drift_tracking_threshold, 8'hFF, "tracking full range");
        HOST.set_tracking(1'b1);
        chk(drift_tracking_threshold, 8'h40, "tracking noisy");
        HOST.set_tracking(1'b0);
        HOST.rd(8'h0C, rd);
        chk(rd, 8'h02, "tracking low");
        conclude();
    end
endmodule

`default_nettype wire
